// >>> hw/light_sensor_defs.svh
// Register offsets, field positions, reset values and codes of the configuration block
`ifndef LIGHT_SENSOR_DEFS_SVH
`define LIGHT_SENSOR_DEFS_SVH

`define AUTOZERO_CONFIG_ADDR      8'hd6
`define INTERRUPT_ENABLE_ADDR     8'hdd
`define AUTOZERO_CONFIG_RESET     8'h7f
`define INTERRUPT_ENABLE_RESET    8'h00
`define SEARCH_START_SELECT_BIT   7
`define AUTOZERO_INTERVAL_MSB     6
`define SATURATION_IRQ_BIT        7
`define LIGHT_THRESHOLD_IRQ_BIT   4
`define INTERVAL_NEVER            7'h00
`define INTERVAL_FIRST_ONLY       7'h7f
`define UNMAPPED_READ_VALUE       8'h00

`endif

// >>> hw/light_sensor_pkg.sv
// Types shared by the configuration block and its auto-zero scheduler
package light_sensor_pkg;

	typedef logic [6:0] interval_t;
	typedef logic [7:0] reg_byte_t;

	typedef enum logic [2:0] {
		SCHED_IDLE    = 3'b001,
		SCHED_FIRST   = 3'b010,
		SCHED_RUNNING = 3'b100
	} sched_state_e;

endpackage

// >>> hw/autozero_sched_if.sv
// Signals between the configuration registers and the auto-zero scheduler
`timescale 1ns/1ps
interface autozero_sched_if;
	light_sensor_pkg::interval_t    interval;
	logic                           meas_enable;
	logic                           cycle_start;
	logic                           run;
	light_sensor_pkg::sched_state_e state;

	modport sched (
		input  interval,
		input  meas_enable,
		input  cycle_start,
		output run,
		output state
	);
	modport ctrl (
		output interval,
		output meas_enable,
		output cycle_start,
		input  run,
		input  state
	);
endinterface

// >>> hw/autozero_scheduler.sv
// Decides on which light-measurement cycles the auto-zero runs
`timescale 1ns/1ps
`include "light_sensor_defs.svh"
module autozero_scheduler (
	input  wire logic           clk_i,
	input  wire logic           rst_n_i,
	autozero_sched_if.sched     az
);

	light_sensor_pkg::sched_state_e state;
	light_sensor_pkg::interval_t    count;
	logic                           run;
	logic                           next_run;
	logic                           count_hit;

	assign az.state = state;
	assign az.run   = run;

	// Count of cycles since the last run, so cycle n, 2n, 3n... hit
	assign count_hit = (7'(count + 7'h01) == az.interval);

	// ****************************************************************
	// Decision per cycle
	// ****************************************************************
	always_comb begin
		next_run = 1'b0;
		if (az.cycle_start && state != light_sensor_pkg::SCHED_IDLE) begin
			if (az.interval == `INTERVAL_NEVER) begin
				next_run = 1'b0;
			end else if (az.interval == `INTERVAL_FIRST_ONLY) begin
				next_run = (state == light_sensor_pkg::SCHED_FIRST);
			end else begin
				next_run = count_hit;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run <= 1'b0;
		end else begin
			run <= next_run;
		end
	end

	// Leaving measurement rearms the first-cycle run
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= light_sensor_pkg::SCHED_IDLE;
		end else begin
			case (state)
				light_sensor_pkg::SCHED_IDLE: begin
					if (az.meas_enable) state <= light_sensor_pkg::SCHED_FIRST;
				end
				light_sensor_pkg::SCHED_FIRST: begin
					if (!az.meas_enable) state <= light_sensor_pkg::SCHED_IDLE;
					else if (az.cycle_start) state <= light_sensor_pkg::SCHED_RUNNING;
				end
				light_sensor_pkg::SCHED_RUNNING: begin
					if (!az.meas_enable) state <= light_sensor_pkg::SCHED_IDLE;
				end
				default: state <= light_sensor_pkg::SCHED_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= 7'h00;
		end else if (state == light_sensor_pkg::SCHED_IDLE) begin
			count <= 7'h00;
		end else if (az.cycle_start) begin
			count <= count_hit ? 7'h00 : 7'(count + 7'h01);
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_never_zero: assert property (az.interval == `INTERVAL_NEVER |=> !run)
		else $error("auto-zero ran with interval zero");
	chk_first_only: assert property (az.cycle_start && state == light_sensor_pkg::SCHED_RUNNING
		&& az.interval == `INTERVAL_FIRST_ONLY |=> !run)
		else $error("auto-zero repeated in first-only mode");
	chk_first_runs: assert property (az.cycle_start && state == light_sensor_pkg::SCHED_FIRST
		&& az.interval == `INTERVAL_FIRST_ONLY |=> run)
		else $error("auto-zero missed the first cycle");
	chk_run_cause: assert property ($rose(run) |-> $past(az.cycle_start))
		else $error("auto-zero run without a measurement cycle");
	chk_every_one: assert property (az.cycle_start && state != light_sensor_pkg::SCHED_IDLE
		&& az.interval == 7'h01 |=> run)
		else $error("interval one did not run on every cycle");

	cov_first_only: cover property (az.interval == `INTERVAL_FIRST_ONLY && run);
	cov_periodic: cover property (az.interval == 7'h03 && run ##[1:40] run);

endmodule

// >>> hw/light_sensor_autozero_irq_config.sv
// Auto-zero and interrupt-enable configuration registers of the light sensor
`timescale 1ns/1ps
`include "light_sensor_defs.svh"
module light_sensor_autozero_irq_config (
	input  wire logic       CLOCK_I,
	input  wire logic       RESET_N_I,
	input  wire logic [7:0] REG_ADDR_I,
	input  wire logic [7:0] REG_WDATA_I,
	input  wire logic       REG_WRITE_I,
	input  wire logic       REG_READ_I,
	output logic      [7:0] REG_RDATA_O,
	input  wire logic       MEAS_ENABLE_I,
	input  wire logic       CYCLE_START_I,
	input  wire logic [7:0] STORED_OFFSET_I,
	input  wire logic       ANALOG_SATURATION_I,
	input  wire logic       LIGHT_THRESHOLD_I,
	output logic            AUTOZERO_RUN_O,
	output logic      [7:0] SEARCH_START_O,
	output logic            INT_OUT_O,
	output logic            INT_OE_N_O
);

	light_sensor_pkg::reg_byte_t autozero_config;
	light_sensor_pkg::reg_byte_t interrupt_enable;
	light_sensor_pkg::reg_byte_t next_rdata;
	light_sensor_pkg::reg_byte_t next_search_start;
	logic                        search_start_select;
	logic                        saturation_irq_enable;
	logic                        light_threshold_irq_enable;
	logic                        next_irq;

	autozero_sched_if az ();

	assign search_start_select        = autozero_config[`SEARCH_START_SELECT_BIT];
	assign saturation_irq_enable      = interrupt_enable[`SATURATION_IRQ_BIT];
	assign light_threshold_irq_enable = interrupt_enable[`LIGHT_THRESHOLD_IRQ_BIT];

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// Reserved bits are kept as written; software is told to write zero
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			autozero_config <= `AUTOZERO_CONFIG_RESET;
		end else if (REG_WRITE_I && REG_ADDR_I == `AUTOZERO_CONFIG_ADDR) begin
			autozero_config <= REG_WDATA_I;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			interrupt_enable <= `INTERRUPT_ENABLE_RESET;
		end else if (REG_WRITE_I && REG_ADDR_I == `INTERRUPT_ENABLE_ADDR) begin
			interrupt_enable <= REG_WDATA_I;
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_comb begin
		if (REG_ADDR_I == `AUTOZERO_CONFIG_ADDR) begin
			next_rdata = autozero_config;
		end else if (REG_ADDR_I == `INTERRUPT_ENABLE_ADDR) begin
			next_rdata = interrupt_enable;
		end else begin
			next_rdata = `UNMAPPED_READ_VALUE;
		end
	end

	// Data holds until the next read
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			REG_RDATA_O <= 8'h00;
		end else if (REG_READ_I) begin
			REG_RDATA_O <= next_rdata;
		end
	end

	// ****************************************************************
	// Auto-zero scheduling and offset search start
	// ****************************************************************
	assign az.interval    = autozero_config[`AUTOZERO_INTERVAL_MSB:0];
	assign az.meas_enable = MEAS_ENABLE_I;
	assign az.cycle_start = CYCLE_START_I;

	autozero_scheduler u_sched (
		.clk_i   (CLOCK_I),
		.rst_n_i (RESET_N_I),
		.az      (az.sched)
	);

	assign AUTOZERO_RUN_O = az.run;

	// Zero start bounds the worst-case search; stored start wins on average
	always_comb begin
		if (search_start_select) begin
			next_search_start = STORED_OFFSET_I;
		end else begin
			next_search_start = 8'h00;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			SEARCH_START_O <= 8'h00;
		end else begin
			SEARCH_START_O <= next_search_start;
		end
	end

	// ****************************************************************
	// Interrupt pin
	// ****************************************************************
	// Flags are owned by the status logic; this block only gates them
	assign next_irq = (ANALOG_SATURATION_I && saturation_irq_enable)
	               || (LIGHT_THRESHOLD_I && light_threshold_irq_enable);

	// Open drain: the pin is only ever pulled low
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			INT_OUT_O  <= 1'b0;
			INT_OE_N_O <= 1'b1;
		end else begin
			INT_OUT_O  <= 1'b0;
			INT_OE_N_O <= !next_irq;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);

	// ****************************************************************
	// Checks: register file
	// ****************************************************************
	chk_interval_write: assert property (REG_WRITE_I && REG_ADDR_I == `AUTOZERO_CONFIG_ADDR
		|=> az.interval == $past(REG_WDATA_I[6:0]))
		else $error("interval field not updated by write");

	chk_select_write: assert property (REG_WRITE_I && REG_ADDR_I == `AUTOZERO_CONFIG_ADDR
		|=> search_start_select == $past(REG_WDATA_I[`SEARCH_START_SELECT_BIT]))
		else $error("search start select not updated by write");

	chk_enable_write: assert property (REG_WRITE_I && REG_ADDR_I == `INTERRUPT_ENABLE_ADDR
		|=> interrupt_enable == $past(REG_WDATA_I))
		else $error("interrupt enables not updated by write");

	// Writes elsewhere, unmapped ones too, must leave both registers alone
	chk_config_hold: assert property (!(REG_WRITE_I && REG_ADDR_I == `AUTOZERO_CONFIG_ADDR)
		|=> $stable(autozero_config))
		else $error("autozero config changed without a write");

	chk_enable_hold: assert property (!(REG_WRITE_I && REG_ADDR_I == `INTERRUPT_ENABLE_ADDR)
		|=> $stable(interrupt_enable))
		else $error("interrupt enables changed without a write");

	chk_read_config: assert property (REG_READ_I && REG_ADDR_I == `AUTOZERO_CONFIG_ADDR
		|=> REG_RDATA_O == $past(autozero_config))
		else $error("wrong autozero config read back");

	chk_read_enable: assert property (REG_READ_I && REG_ADDR_I == `INTERRUPT_ENABLE_ADDR
		|=> REG_RDATA_O == $past(interrupt_enable))
		else $error("wrong interrupt enables read back");

	// ****************************************************************
	// Checks: offset search start and scheduling
	// ****************************************************************
	chk_start_zero: assert property (!search_start_select |=> SEARCH_START_O == 8'h00)
		else $error("search did not start from zero");

	chk_start_stored: assert property (search_start_select |=> SEARCH_START_O == $past(STORED_OFFSET_I))
		else $error("search did not start from stored offset");

	chk_idle_no_run: assert property (az.state == light_sensor_pkg::SCHED_IDLE
		|=> !AUTOZERO_RUN_O)
		else $error("auto-zero ran while measurement was idle");

	// ****************************************************************
	// Checks: interrupt pin
	// ****************************************************************
	chk_sat_irq: assert property (ANALOG_SATURATION_I && saturation_irq_enable |=> !INT_OE_N_O)
		else $error("saturation did not raise the interrupt");

	chk_light_irq: assert property (LIGHT_THRESHOLD_I && light_threshold_irq_enable |=> !INT_OE_N_O)
		else $error("threshold event did not raise the interrupt");

	chk_irq_gated: assert property (!(ANALOG_SATURATION_I && saturation_irq_enable)
		&& !(LIGHT_THRESHOLD_I && light_threshold_irq_enable) |=> INT_OE_N_O)
		else $error("interrupt asserted without an enabled flag");

	chk_sat_masked: assert property (ANALOG_SATURATION_I && !saturation_irq_enable
		&& !LIGHT_THRESHOLD_I |=> INT_OE_N_O)
		else $error("masked saturation raised the interrupt");

	chk_light_masked: assert property (LIGHT_THRESHOLD_I && !light_threshold_irq_enable
		&& !ANALOG_SATURATION_I |=> INT_OE_N_O)
		else $error("masked threshold event raised the interrupt");

	chk_int_level: assert property (!INT_OE_N_O |-> !INT_OUT_O)
		else $error("interrupt pin driven high");

	// ****************************************************************
	// Checks: reset values
	// ****************************************************************
	// Enabled during reset, where the default disable would hide them
	chk_reset_regs: assert property (disable iff (1'b0) !RESET_N_I ##1 !RESET_N_I
		|-> autozero_config == `AUTOZERO_CONFIG_RESET && interrupt_enable == `INTERRUPT_ENABLE_RESET)
		else $error("registers not at reset values during reset");

	chk_reset_pin: assert property (disable iff (1'b0) !RESET_N_I ##1 !RESET_N_I
		|-> INT_OE_N_O && !INT_OUT_O)
		else $error("interrupt pin not released during reset");

	cov_sat_irq: cover property (ANALOG_SATURATION_I && saturation_irq_enable ##1 !INT_OE_N_O);
	cov_stored_start: cover property (search_start_select && AUTOZERO_RUN_O);
	cov_masked: cover property (LIGHT_THRESHOLD_I && !light_threshold_irq_enable ##1 INT_OE_N_O);

endmodule

// >>> verification/sensor_host_model.sv
// Host model that reaches the configuration registers and watches the interrupt line
`timescale 1ns/1ps
module sensor_host_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       int_oe_n_i,
	input  wire logic       int_out_i,
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            write_o,
	output logic            read_o,
	output wire logic       int_line_o
);
	// Open-drain line with a board pull-up
	assign int_line_o = int_oe_n_i ? 1'b1 : int_out_i;

	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		write_o = 1'b0;
		read_o = 1'b0;
	end

	// Released lines show the inverse, so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		addr_o = a;
		wdata_o = d;
		write_o = 1'b1;
		@(posedge clk_i);
		#1;
		write_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		addr_o = a;
		read_o = 1'b1;
		@(posedge clk_i);
		#1;
		read_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
	endtask
endmodule

// >>> verification/light_sensor_autozero_irq_config_test.sv
// Self-checking bench of the auto-zero and interrupt-enable configuration block
`timescale 1ns/1ps
`include "light_sensor_defs.svh"
module light_sensor_autozero_irq_config_test;
	logic       clk = 1'b0;
	logic       rst_n;
	logic       meas_en;
	logic       cyc_start;
	logic       sat;
	logic       light;
	logic [7:0] stored;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] search;
	logic       wr_s;
	logic       rd_s;
	logic       az_run;
	logic       int_out;
	logic       int_oe_n;
	wire        int_line;
	int         n_mismatch = 0;
	int         num_checks = 0;

	always #25 clk = ~clk;

	light_sensor_autozero_irq_config dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WRITE_I(wr_s), .REG_READ_I(rd_s), .REG_RDATA_O(rdata),
		.MEAS_ENABLE_I(meas_en), .CYCLE_START_I(cyc_start), .STORED_OFFSET_I(stored),
		.ANALOG_SATURATION_I(sat), .LIGHT_THRESHOLD_I(light), .AUTOZERO_RUN_O(az_run),
		.SEARCH_START_O(search), .INT_OUT_O(int_out), .INT_OE_N_O(int_oe_n));

	sensor_host_model host (.clk_i(clk), .rdata_i(rdata), .int_oe_n_i(int_oe_n), .int_out_i(int_out),
		.addr_o(addr), .wdata_o(wdata), .write_o(wr_s), .read_o(rd_s), .int_line_o(int_line));

	// ****************************************
	// Compare and closing
	// ****************************************
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_regs();
		logic [7:0] v;
		host.rd(`AUTOZERO_CONFIG_ADDR, v);
		chk("autozero_config reset", 8'h7f, v);
		host.rd(`INTERRUPT_ENABLE_ADDR, v);
		chk("interrupt_enable reset", 8'h00, v);
		host.wr(`AUTOZERO_CONFIG_ADDR, 8'h83);
		host.rd(`AUTOZERO_CONFIG_ADDR, v);
		chk("autozero_config", 8'h83, v);
		host.wr(`INTERRUPT_ENABLE_ADDR, 8'h69);
		host.rd(`INTERRUPT_ENABLE_ADDR, v);
		chk("interrupt_enable", 8'h69, v);
		// Placed after a non-zero read so a stale read value cannot pass
		host.wr(8'h55, 8'ha5);
		host.rd(8'h55, v);
		chk("unmapped read", 8'h00, v);
		host.rd(`AUTOZERO_CONFIG_ADDR, v);
		chk("autozero_config after unmapped write", 8'h83, v);
		$display("test_regs done");
	endtask

	task automatic test_start_select();
		stored = 8'h5a;
		for (int s = 0; s < 2; s++) begin
			host.wr(`AUTOZERO_CONFIG_ADDR, {s[0], 7'h01});
			repeat (2) @(posedge clk);
			#1;
			chk("search start", s[0] ? 8'h5a : 8'h00, search);
		end
		$display("test_start_select done");
	endtask

	// Only a whole pattern catches a wrong phase of the interval count
	task automatic test_interval();
		logic [6:0] ivs [4] = '{7'h00, 7'h01, 7'h03, 7'h7f};
		logic       e;
		foreach (ivs[j]) begin
			host.wr(`AUTOZERO_CONFIG_ADDR, {1'b0, ivs[j]});
			meas_en = 1'b1;
			@(posedge clk);
			#1;
			for (int k = 1; k <= 7; k++) begin
				cyc_start = 1'b1;
				@(posedge clk);
				#1;
				cyc_start = 1'b0;
				e = (ivs[j] == 7'h7f) ? (k == 1) : (ivs[j] != 7'h00 && k % ivs[j] == 0);
				chk("autozero run", {7'h00, e}, {7'h00, az_run});
				@(posedge clk);
				#1;
			end
			meas_en = 1'b0;
			repeat (2) @(posedge clk);
			#1;
		end
		$display("test_interval done");
	endtask

	task automatic test_irq();
		logic [3:0] c;
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			host.wr(`INTERRUPT_ENABLE_ADDR, {c[0], 2'b00, c[1], 4'h0});
			sat = c[2];
			light = c[3];
			repeat (2) @(posedge clk);
			#1;
			chk("int line", {7'h00, !((c[2] & c[0]) | (c[3] & c[1]))}, {7'h00, int_line});
		end
		$display("test_irq done");
	endtask

	// Reset in mid-run must restore both registers and release the pin
	task automatic test_reset();
		logic [7:0] v;
		light = 1'b0;
		host.wr(`INTERRUPT_ENABLE_ADDR, 8'h90);
		sat = 1'b1;
		host.wr(`AUTOZERO_CONFIG_ADDR, 8'h85);
		chk("int line before reset", 8'h00, {7'h00, int_line});
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("int line in reset", 8'h01, {7'h00, int_line});
		rst_n = 1'b1;
		host.rd(`AUTOZERO_CONFIG_ADDR, v);
		chk("autozero_config after reset", `AUTOZERO_CONFIG_RESET, v);
		host.rd(`INTERRUPT_ENABLE_ADDR, v);
		chk("interrupt_enable after reset", `INTERRUPT_ENABLE_RESET, v);
		chk("int line after reset", 8'h01, {7'h00, int_line});
		sat = 1'b0;
		$display("test_reset done");
	endtask

	initial begin
		#100000;
		n_mismatch++;
		results();
	end

	initial begin
		rst_n = 1'b0;
		meas_en = 1'b0;
		cyc_start = 1'b0;
		sat = 1'b0;
		light = 1'b0;
		stored = 8'h00;
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		test_regs();
		test_start_select();
		test_interval();
		test_irq();
		test_reset();
		results();
	end
endmodule
